// ===== ssw_chk_sva.sv
`timescale 1ns/10ps
module ssw_chk #(
    parameter ssw_pkg::ssw_cnt_type RESET_CYCLES = 28'h000_0014,
    parameter ssw_pkg::ssw_cnt_type WDOG_CYCLES = 28'h000_0032
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Inputs
    input wire logic supply_low,
    input wire logic power_fail_low,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick,
    input wire logic watchdog_kick_float,
    // Outputs
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic watchdog_expired_n,
    input wire logic power_fail_flag_n
);
    int rq;
    int wq;
    logic kq;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Quiet cycles while reset is held, and cycles since the watchdog was last cleared.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rq <= 0;
            wq <= 0;
            kq <= 1'b0;
        end else begin
            rq <= (supply_low | !manual_reset_n | reset_out_n) ? 0 : rq + 1;
            wq <= (!reset_out_n | watchdog_kick_float | (watchdog_kick != kq)) ? 0 : wq + 1;
            kq <= watchdog_kick;
        end
    end
    a_high_low_compl: assert property (reset_out == !reset_out_n) else $error("polarity");
    a_manual_starts: assert property (!manual_reset_n |=> !reset_out_n) else $error("manual");
    a_supply_holds: assert property (supply_low |=> !reset_out_n) else $error("supply");
    a_supply_wdo: assert property (supply_low |=> !watchdog_expired_n) else $error("wdo low");
    a_wdo_release: assert property ($fell(supply_low) |=> watchdog_expired_n) else $error("wdo rel");
    a_stretch_min: assert property ($rose(reset_out_n) |-> rq >= RESET_CYCLES) else $error("short");
    a_stretch_max: assert property (rq <= RESET_CYCLES + 2) else $error("long");
    a_pfo_follow: assert property (1'b1 |=> power_fail_flag_n == !$past(power_fail_low)) else $error("pfo");
    a_wdog_late: assert property (wq > WDOG_CYCLES + 2 |-> !watchdog_expired_n) else $error("late");
    a_wdog_early: assert property ($fell(watchdog_expired_n) && !$past(supply_low) |-> wq >= WDOG_CYCLES - 2)
        else $error("early");
endmodule // ssw_chk
bind ssw_supervisor ssw_chk #(.RESET_CYCLES(RESET_CYCLES), .WDOG_CYCLES(WDOG_CYCLES)) i_chk (.clk(clk),
    .rst_b(rst_b), .supply_low(supply_low), .power_fail_low(power_fail_low), .manual_reset_n(manual_reset_n),
    .watchdog_kick(watchdog_kick), .watchdog_kick_float(watchdog_kick_float), .reset_out_n(reset_out_n),
    .reset_out(reset_out), .watchdog_expired_n(watchdog_expired_n), .power_fail_flag_n(power_fail_flag_n));

// ===== ssw_cpu.sv
`timescale 1ns/10ps
module ssw_cpu #(
    parameter int HALF = 10
) (
    // Clock
    input wire logic clk,
    // Program alive and kick pin
    input wire logic en,
    output logic kick
);
    // A stopped program leaves the kick level steady, as a hung processor would.
    initial kick = 1'b0;
    always begin
        repeat (HALF) @(posedge clk);
        if (en) kick <= ~kick;
    end
endmodule // ssw_cpu

// ===== ssw_map.svh
`ifndef SSW_MAP_SVH
`define SSW_MAP_SVH
// Clock rate and documented intervals.
`define SSW_CLK_HZ 125000000
`define SSW_RESET_MS 200
`define SSW_WDOG_MS 1600
`define SSW_MS_DIV 1000
// Cycle counts derived from the rate.
`define SSW_RESET_CYC ((`SSW_CLK_HZ / `SSW_MS_DIV) * `SSW_RESET_MS)
`define SSW_WDOG_CYC ((`SSW_CLK_HZ / `SSW_MS_DIV) * `SSW_WDOG_MS)
`define SSW_CNT_W 28
`endif

// ===== ssw_pkg.sv
package ssw_pkg;
    typedef logic [27:0] ssw_cnt_type;
    typedef enum logic [2:0] {
        SSW_ST_IDLE = 3'h1,
        SSW_ST_HOLD = 3'h2,
        SSW_ST_STRETCH = 3'h4
    } ssw_state_type;
endpackage

// ===== ssw_supervisor.sv
`timescale 1ns/10ps
`include "ssw_map.svh"
// Overview of operation
// - Manual reset low starts a reset pulse.
// - Reset pulse lasts 200 ms.
// - Reset held while supply is low.
// - Stretch 200 ms after supply or manual release.
// - Watchdog expiry never drives reset directly.
// - Watchdog times out after 1.6 s steady kick.
// - Tri-stated kick disables the watchdog.
// - Timer clears on reset, tri-state, kick edge.
// - Expired output low until timer clears.
// - Expired output low while supply is low.
// - Expired output releases at once, no stretch.
// - High reset is complement of low reset.
// - Power-fail flag low below sense threshold.
// - Variant may offer only high reset.
module ssw_supervisor #(
    parameter ssw_pkg::ssw_cnt_type RESET_CYCLES = ssw_pkg::ssw_cnt_type'(`SSW_RESET_CYC),
    parameter ssw_pkg::ssw_cnt_type WDOG_CYCLES = ssw_pkg::ssw_cnt_type'(`SSW_WDOG_CYC),
    parameter bit HAS_WATCHDOG = 1'b1,
    parameter bit HAS_RESET_LOW = 1'b1,
    parameter bit HAS_RESET_HIGH = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Comparator results and pins
    input wire logic supply_low,
    input wire logic power_fail_low,
    input wire logic manual_reset_n,
    input wire logic watchdog_kick,
    input wire logic watchdog_kick_float,
    // Outputs to the processor
    output logic reset_out_n,
    output logic reset_out,
    output logic watchdog_expired_n,
    output logic power_fail_flag_n
);
    import ssw_pkg::*;

    // Either cause keeps the processor in reset; the sequencer tests it in every state.
    function automatic logic reset_cause(input logic low_supply, input logic manual_n);
        return low_supply || !manual_n;
    endfunction

    ssw_state_type state_r;
    ssw_state_type state_nxt;
    logic rst_asserted;
    logic stretch_load;
    logic stretch_done;
    logic kick_r;
    logic kick_nxt;
    logic kick_seen_r;
    logic kick_seen_nxt;
    logic wd_clear;
    logic wd_done;
    logic reset_n_r;
    logic reset_n_nxt;
    logic reset_h_r;
    logic reset_h_nxt;
    logic wdo_n_r;
    logic wdo_n_nxt;
    logic pfo_n_r;
    logic pfo_n_nxt;

    // Reset sequencer: a hold state while a cause is present, then a stretch.
    always_comb begin
        state_nxt = state_r;
        stretch_load = 1'b0;
        case (state_r)
            SSW_ST_IDLE: begin
                if (reset_cause(supply_low, manual_reset_n)) begin
                    state_nxt = SSW_ST_HOLD;
                end
            end
            SSW_ST_HOLD: begin
                if (!reset_cause(supply_low, manual_reset_n)) begin
                    state_nxt = SSW_ST_STRETCH;
                    stretch_load = 1'b1;
                end
            end
            SSW_ST_STRETCH: begin
                if (reset_cause(supply_low, manual_reset_n)) begin
                    state_nxt = SSW_ST_HOLD;
                end else if (stretch_done) begin
                    state_nxt = SSW_ST_IDLE;
                end
            end
            default: begin
                state_nxt = SSW_ST_HOLD;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= SSW_ST_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Shared timer module counts the 200 ms stretch.
    ssw_timer u_stretch (
        .clk(clk),
        .rst_b(rst_b),
        .load(stretch_load),
        .load_value(RESET_CYCLES - 28'h000_0001),
        .run(state_r == SSW_ST_STRETCH),
        .done(stretch_done)
    );

    // Reset request as seen one cycle ahead of the registered outputs.
    assign rst_asserted = (state_nxt != SSW_ST_IDLE);

    // Kick edge detector; inputs are already synchronous to clk.
    always_comb begin
        kick_nxt = watchdog_kick;
        kick_seen_nxt = !watchdog_kick_float;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kick_r <= 1'b0;
            kick_seen_r <= 1'b0;
        end else begin
            kick_r <= kick_nxt;
            kick_seen_r <= kick_seen_nxt;
        end
    end

    // The timer also clears when the previous sample was not driven.
    assign wd_clear = (state_r != SSW_ST_IDLE) || watchdog_kick_float || !kick_seen_r
        || (watchdog_kick != kick_r) || !HAS_WATCHDOG;

    ssw_timer u_watchdog (
        .clk(clk),
        .rst_b(rst_b),
        .load(wd_clear),
        .load_value(WDOG_CYCLES - 28'h000_0001),
        .run(HAS_WATCHDOG && !watchdog_kick_float),
        .done(wd_done)
    );

    // Registered outputs; watchdog expiry feeds only its own pin.
    always_comb begin
        reset_n_nxt = !(rst_asserted && HAS_RESET_LOW);
        reset_h_nxt = rst_asserted && (HAS_RESET_HIGH || !HAS_RESET_LOW);
        wdo_n_nxt = !((wd_done && !wd_clear) || supply_low);
        if (!HAS_WATCHDOG) begin
            wdo_n_nxt = 1'b1;
        end
        pfo_n_nxt = !power_fail_low;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_n_r <= 1'b0;
            reset_h_r <= 1'b1;
            wdo_n_r <= 1'b1;
            pfo_n_r <= 1'b1;
        end else begin
            reset_n_r <= reset_n_nxt;
            reset_h_r <= reset_h_nxt;
            wdo_n_r <= wdo_n_nxt;
            pfo_n_r <= pfo_n_nxt;
        end
    end

    assign reset_out_n = reset_n_r;
    assign reset_out = reset_h_r;
    assign watchdog_expired_n = wdo_n_r;
    assign power_fail_flag_n = pfo_n_r;
endmodule // ssw_supervisor

// ===== ssw_timer.sv
`timescale 1ns/10ps
`include "ssw_map.svh"
// Loadable down counter shared by the reset stretch and the watchdog.
module ssw_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control
    input wire logic load,
    input wire ssw_pkg::ssw_cnt_type load_value,
    input wire logic run,
    // Status
    output logic done
);
    import ssw_pkg::*;
    ssw_cnt_type cnt_r;
    ssw_cnt_type cnt_nxt;
    logic done_r;
    logic done_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        done_nxt = done_r;
        if (load) begin
            cnt_nxt = load_value;
            done_nxt = 1'b0;
        end else if (run && !done_r) begin
            if (cnt_r <= 28'h000_0001) begin
                done_nxt = 1'b1;
            end
            cnt_nxt = cnt_r - 28'h000_0001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 28'h000_0000;
            done_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done = done_r;
endmodule // ssw_timer

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ssw_pkg::*;
    localparam ssw_cnt_type RC = 28'h000_0014;
    localparam ssw_cnt_type WC = 28'h000_0032;
    logic clk = 1'b0, rst_b = 1'b0, sl = 1'b0, pfl = 1'b0, mr_n = 1'b1, flt = 1'b0, en = 1'b1;
    logic kick, ro_n, ro, wdo_n, pfo_n;
    int failures = 0, checks_done = 0, cyc = 0;
    always #4 clk = ~clk;
    ssw_cpu #(.HALF(10)) i_cpu (.clk(clk), .en(en), .kick(kick));
    ssw_supervisor #(.RESET_CYCLES(RC), .WDOG_CYCLES(WC), .HAS_RESET_HIGH(1'b1)) i_dut (.clk(clk),
        .rst_b(rst_b), .supply_low(sl), .power_fail_low(pfl), .manual_reset_n(mr_n), .watchdog_kick(kick),
        .watchdog_kick_float(flt), .reset_out_n(ro_n), .reset_out(ro), .watchdog_expired_n(wdo_n),
        .power_fail_flag_n(pfo_n));
    task chk(input string n, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task t_manual;
        @(posedge clk);
        mr_n <= 1'b0;
        w(2);
        chk("rst_n", 1'b0, ro_n);
        chk("rst", 1'b1, ro);
        @(posedge clk);
        mr_n <= 1'b1;
        w(RC - 2);
        chk("rst_n", 1'b0, ro_n);
        w(6);
        chk("rst_n", 1'b1, ro_n);
        chk("rst", 1'b0, ro);
        $display("manual done");
    endtask
    task t_supply;
        @(posedge clk);
        sl <= 1'b1;
        w(39);
        chk("rst_n", 1'b0, ro_n);
        chk("wdo_n", 1'b0, wdo_n);
        @(posedge clk);
        sl <= 1'b0;
        w(1);
        chk("wdo_n", 1'b1, wdo_n);
        chk("rst_n", 1'b0, ro_n);
        w(RC + 4);
        chk("rst_n", 1'b1, ro_n);
        $display("supply done");
    endtask
    task t_wdog;
        @(posedge clk);
        en <= 1'b0;
        w(WC - 11);
        chk("wdo_n", 1'b1, wdo_n);
        w(15);
        chk("wdo_n", 1'b0, wdo_n);
        chk("rst_n", 1'b1, ro_n);
        @(posedge clk);
        en <= 1'b1;
        w(11);
        chk("wdo_n", 1'b1, wdo_n);
        @(posedge clk);
        en <= 1'b0;
        flt <= 1'b1;
        w(WC + 19);
        chk("wdo_n", 1'b1, wdo_n);
        @(posedge clk);
        en <= 1'b1;
        flt <= 1'b0;
        pfl <= 1'b1;
        w(1);
        chk("pfo_n", 1'b0, pfo_n);
        @(posedge clk);
        pfl <= 1'b0;
        w(1);
        chk("pfo_n", 1'b1, pfo_n);
        $display("watchdog done");
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 3000) begin
            failures++;
            report_and_stop;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        w(RC + 6);
        chk("rst_n", 1'b1, ro_n);
        t_manual;
        t_supply;
        t_wdog;
        report_and_stop;
    end
endmodule // tb_top
